// >>> verilog/mdf_pkg.sv
// constants, codes and types of the microprogram dispatch forks
// assumes a single processor clock shared with sequencer and fetch unit
package mdf_pkg;

	////////////////////////////////////////////////////////////////////
	// widths
	localparam int WORD_W  = 16; // instruction word width
	localparam int STATE_W = 5;  // width of a dispatch target code
	localparam int MODE_W  = 3;  // width of an addressing mode field

	////////////////////////////////////////////////////////////////////
	// instruction word field positions
	localparam int SRC_MODE_LSB = 9; // third octal digit from the top
	localparam int DST_MODE_LSB = 3; // fifth octal digit from the top
	localparam int BYTE_BIT     = 15; // byte flag of word/byte pairs

	////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] WORD_RST = 16'h0000;

	////////////////////////////////////////////////////////////////////
	// dispatch target codes (machine state entered from a fork)
	typedef logic [4:0] mdf_target_t;
	localparam mdf_target_t T_NONE          = 5'h00;
	localparam mdf_target_t T_FETCH_START   = 5'h01;
	localparam mdf_target_t T_FETCH_SECOND  = 5'h02;
	localparam mdf_target_t T_BRANCH_TAKE   = 5'h03;
	localparam mdf_target_t T_DIVIDE_SETUP  = 5'h04;
	localparam mdf_target_t T_TRAP_ENTRY    = 5'h05;
	localparam mdf_target_t T_SUB_CALL      = 5'h06;
	localparam mdf_target_t T_MOVE_FROM_REG = 5'h07;
	localparam mdf_target_t T_MOVE_FROM_EX  = 5'h08;
	localparam mdf_target_t T_DIVIDE_EXEC   = 5'h09;
	localparam mdf_target_t T_JUMP_EXEC     = 5'h0A;
	localparam mdf_target_t T_EXEC_COMMON   = 5'h0B;
	localparam mdf_target_t T_TEST_EXEC     = 5'h0C;
	localparam mdf_target_t T_SRC_M13       = 5'h0D;
	localparam mdf_target_t T_SRC_M45       = 5'h0E;
	localparam mdf_target_t T_SRC_M67       = 5'h0F;
	localparam mdf_target_t T_DST_REG       = 5'h10;
	localparam mdf_target_t T_DST_M12       = 5'h11;
	localparam mdf_target_t T_DST_M30       = 5'h12;
	localparam mdf_target_t T_DST_M45       = 5'h13;
	localparam mdf_target_t T_DST_M67       = 5'h14;
	localparam mdf_target_t T_STO_REG       = 5'h15;
	localparam mdf_target_t T_STO_M12       = 5'h16;
	localparam mdf_target_t T_STO_M30       = 5'h17;
	localparam mdf_target_t T_STO_M45       = 5'h18;
	localparam mdf_target_t T_STO_M67       = 5'h19;
	localparam mdf_target_t T_OTHER_SEQ     = 5'h1A;

	////////////////////////////////////////////////////////////////////
	// per-mode lookup tables, entry for mode m at bits [5*m +: 5]
	localparam logic [39:0] SRC_TABLE = {T_SRC_M67, T_SRC_M67, T_SRC_M45,
		T_SRC_M45, T_SRC_M13, T_SRC_M13, T_SRC_M13, T_NONE};
	localparam logic [39:0] DST_TABLE = {T_DST_M67, T_DST_M67, T_DST_M45,
		T_DST_M45, T_DST_M30, T_DST_M12, T_DST_M12, T_DST_REG};
	localparam logic [39:0] STO_TABLE = {T_STO_M67, T_STO_M67, T_STO_M45,
		T_STO_M45, T_STO_M30, T_STO_M12, T_STO_M12, T_STO_REG};

	////////////////////////////////////////////////////////////////////
	// instruction identities
	typedef enum logic [3:0] {
		ID_NONE   = 4'h0, // no instruction maps to this word
		ID_DOUBLE = 4'h1, // double operand, general
		ID_CMPBIT = 4'h2, // double operand, compare or test
		ID_MOVE   = 4'h3, // double operand move, no fork b
		ID_SINGLE = 4'h4, // single operand
		ID_BRCOND = 4'h5, // conditional branch
		ID_BRUNC  = 4'h6, // unconditional branch
		ID_DIV    = 4'h7, // divide
		ID_JSR    = 4'h8, // jump to subroutine
		ID_JMP    = 4'h9, // jump
		ID_MFU    = 4'hA, // move from previous space
		ID_TRAP   = 4'hB, // software trap group
		ID_OTHER  = 4'hC  // own first state, no later forks
	} mdf_id_t;

	////////////////////////////////////////////////////////////////////
	// last bus transfer of the destination fetch
	typedef enum logic [1:0] {
		CYC_NONE       = 2'h0,
		CYC_READ       = 2'h1, // read_cycle
		CYC_READ_PAUSE = 2'h2, // read_pause_cycle
		CYC_WRITE      = 2'h3  // write_cycle
	} mdf_cycle_t;

	////////////////////////////////////////////////////////////////////
	// decoder phase, one-hot
	typedef enum logic [1:0] {
		PH_WAIT   = 2'b01, // waiting for a fetched word
		PH_DECODE = 2'b10  // instruction_decode_state, fork a enabled
	} mdf_phase_t;

endpackage

// >>> verilog/mdf_mode_lookup.sv
// one per-mode lookup: an addressing mode picks a dispatch target
// assumes the table is packed eight entries of STATE_W bits, mode 0 low
module mdf_mode_lookup #(
	parameter int          STATE_W = 5,
	parameter logic [39:0] TABLE   = 40'h0
) (
	input  wire logic [2:0]         mode,
	output      logic [STATE_W-1:0] target
);

	////////////////////////////////////////////////////////////////////
	// indexed part-select of the packed table
	always_comb begin
		target = TABLE[STATE_W*mode +: STATE_W];
	end

endmodule

// >>> verilog/mdf_dispatch.sv
// instruction dispatch forks a, b and c of the microprogram sequencer
// assumes fetch, sequencer and condition inputs share clk; no pins
// How it works
// - each 16-bit word maps to one identity
// - fetched word lands in both holding registers
// - every instruction dispatches through fork a
// - forks b and c answer only users
// - classes end destination fetch with their cycle
// - fetch return picks start or second state
// - branch taken when condition met, else fetch
// - double operand: source mode lookup
// - single or register source: destination lookup
// - fork c: destination mode lookup
// - divide register mode goes to setup
// - subroutine call register mode traps
// - move-from register mode uses own state
// - fork a enabled in decode state
// - source mode is third octal digit
module mdf_dispatch (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        fetch_load,
	input  wire logic [15:0] fetch_word,
	input  wire logic        async_request,
	input  wire logic        branch_condition_met,
	input  wire logic        fork_b_req,
	input  wire logic        fork_c_req,
	output      logic [15:0] instruction_register,
	output      logic [15:0] buffer_register,
	output      logic [3:0]  instr_id,
	output      logic [1:0]  dest_fetch_cycle,
	output      logic        fork_a_valid,
	output      logic [4:0]  fork_a_target,
	output      logic        fork_b_valid,
	output      logic [4:0]  fork_b_target,
	output      logic        fork_c_valid,
	output      logic [4:0]  fork_c_target,
	output      logic        fork_unused
);

	////////////////////////////////////////////////////////////////////
	// state
	mdf_pkg::mdf_phase_t phase_q, phase_d;     // decoder phase
	logic [15:0]         ir_q, ir_d;           // instruction_register
	logic [15:0]         br_q, br_d;           // buffer_register
	mdf_pkg::mdf_id_t    id_q, id_d;           // registered identity
	mdf_pkg::mdf_cycle_t cyc_q, cyc_d;         // destination fetch end
	logic                fa_v_q, fa_v_d;       // fork a answer strobe
	logic [4:0]          fa_t_q, fa_t_d;       // fork a target
	logic                fb_v_q, fb_v_d;       // fork b answer strobe
	logic [4:0]          fb_t_q, fb_t_d;       // fork b target
	logic                fc_v_q, fc_v_d;       // fork c answer strobe
	logic [4:0]          fc_t_q, fc_t_d;       // fork c target
	logic                nu_q, nu_d;           // fork asked but unused

	// combinational decode of the held word
	mdf_pkg::mdf_id_t    id_c;                 // identity of ir_q
	mdf_pkg::mdf_cycle_t cyc_c;                // class of ir_q
	logic [2:0]          src_mode;             // source mode field
	logic [2:0]          dst_mode;             // destination mode field
	logic                dest_mode_zero;       // register destination
	logic [4:0]          src_tgt;              // source lookup result
	logic [4:0]          dst_tgt;              // destination lookup
	logic [4:0]          sto_tgt;              // store lookup result
	logic [4:0]          fetch_tgt;            // fetch return target
	logic                uses_b;               // fork b in use
	logic                uses_c;               // fork c in use

	////////////////////////////////////////////////////////////////////
	// mode fields
	// third octal digit
	assign src_mode = ir_q[mdf_pkg::SRC_MODE_LSB +: mdf_pkg::MODE_W];
	assign dst_mode = ir_q[mdf_pkg::DST_MODE_LSB +: mdf_pkg::MODE_W];
	assign dest_mode_zero = (dst_mode == 3'h0);

	mdf_mode_lookup #(
		.STATE_W (mdf_pkg::STATE_W),
		.TABLE   (mdf_pkg::SRC_TABLE)
	) u_src (
		.mode   (src_mode),
		.target (src_tgt)
	);

	mdf_mode_lookup #(
		.STATE_W (mdf_pkg::STATE_W),
		.TABLE   (mdf_pkg::DST_TABLE)
	) u_dst (
		.mode   (dst_mode),
		.target (dst_tgt)
	);

	mdf_mode_lookup #(
		.STATE_W (mdf_pkg::STATE_W),
		.TABLE   (mdf_pkg::STO_TABLE)
	) u_sto (
		.mode   (dst_mode),
		.target (sto_tgt)
	);

	////////////////////////////////////////////////////////////////////
	// identity and class of the held word
	// word to identity
	always_comb begin
		id_c  = mdf_pkg::ID_NONE;
		cyc_c = mdf_pkg::CYC_NONE;
		casez (ir_q[15:6])
			// double operand groups 1..6 and byte forms
			10'b?001??????: begin
				id_c  = mdf_pkg::ID_MOVE;
				cyc_c = ir_q[mdf_pkg::BYTE_BIT] ? mdf_pkg::CYC_READ_PAUSE
					: mdf_pkg::CYC_WRITE;
			end
			10'b?010??????, 10'b?011??????: begin
				id_c  = mdf_pkg::ID_CMPBIT;
				cyc_c = mdf_pkg::CYC_READ;
			end
			10'b?100??????, 10'b?101??????, 10'b?110??????: begin
				id_c  = mdf_pkg::ID_DOUBLE;
				cyc_c = mdf_pkg::CYC_READ_PAUSE;
			end
			// extended group
			10'b0111001???: begin
				id_c  = mdf_pkg::ID_DIV;
				cyc_c = mdf_pkg::CYC_READ;
			end
			10'b0111111???: id_c = mdf_pkg::ID_OTHER;
			10'b0111000???, 10'b011101????, 10'b0111100???: begin
				id_c  = mdf_pkg::ID_SINGLE;
				cyc_c = mdf_pkg::CYC_READ;
			end
			// jumps
			10'b0000000001: id_c = mdf_pkg::ID_JMP;
			10'b0000100???: id_c = mdf_pkg::ID_JSR;
			// move from previous space, word and byte forms
			10'b?000110101: begin
				id_c  = mdf_pkg::ID_MFU;
				cyc_c = mdf_pkg::CYC_READ;
			end
			10'b0000110100, 10'b0000110110: id_c = mdf_pkg::ID_OTHER;
			// software traps with operand field, ahead of the
			// single operand group whose pattern overlaps them
			10'b1000100???: id_c = mdf_pkg::ID_TRAP;
			// single operand
			10'b0000000011, 10'b?00010????, 10'b?000110???: begin
				id_c  = mdf_pkg::ID_SINGLE;
				cyc_c = mdf_pkg::CYC_READ_PAUSE;
			end
			// branches, upper group stops below the trap words
			10'b00000001??: id_c = mdf_pkg::ID_BRUNC;
			10'b0000001???, 10'b000001????, 10'b10000?????:
				id_c = mdf_pkg::ID_BRCOND;
			// misc group: trap words and others
			10'b0000000000: begin
				if (ir_q[5:0] == 6'h03 || ir_q[5:0] == 6'h04) begin
					id_c = mdf_pkg::ID_TRAP;
				end else if (ir_q[5:0] <= 6'h06) begin
					id_c = mdf_pkg::ID_OTHER;
				end
			end
			10'b0000000010: id_c = mdf_pkg::ID_OTHER;
			default: id_c = mdf_pkg::ID_NONE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// fork a target
	// fetch return choice
	assign fetch_tgt = async_request ? mdf_pkg::T_FETCH_START
		: mdf_pkg::T_FETCH_SECOND;

	// every identity gets a fork a target
	always_comb begin
		fa_t_d = mdf_pkg::T_OTHER_SEQ;
		case (id_c)
			// source mode, register source via destination
			mdf_pkg::ID_DOUBLE, mdf_pkg::ID_CMPBIT, mdf_pkg::ID_MOVE:
				fa_t_d = (src_mode == 3'h0) ? dst_tgt : src_tgt;
			mdf_pkg::ID_SINGLE: fa_t_d = dst_tgt;
			mdf_pkg::ID_BRCOND:
				fa_t_d = branch_condition_met ? mdf_pkg::T_BRANCH_TAKE
					: fetch_tgt;
			mdf_pkg::ID_BRUNC: fa_t_d = mdf_pkg::T_BRANCH_TAKE;
			mdf_pkg::ID_DIV:
				fa_t_d = dest_mode_zero ? mdf_pkg::T_DIVIDE_SETUP : dst_tgt;
			mdf_pkg::ID_JSR, mdf_pkg::ID_JMP:
				fa_t_d = dest_mode_zero ? mdf_pkg::T_TRAP_ENTRY : dst_tgt;
			mdf_pkg::ID_MFU:
				fa_t_d = dest_mode_zero ? mdf_pkg::T_MOVE_FROM_REG : dst_tgt;
			mdf_pkg::ID_TRAP: fa_t_d = mdf_pkg::T_TRAP_ENTRY;
			mdf_pkg::ID_NONE: fa_t_d = mdf_pkg::T_TRAP_ENTRY;
			default: fa_t_d = mdf_pkg::T_OTHER_SEQ;
		endcase
		// hold the answer outside the decode state
		if (phase_q != mdf_pkg::PH_DECODE) begin
			fa_t_d = fa_t_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// later fork users and targets
	// which instructions use forks b and c
	always_comb begin
		uses_b = 1'b1;
		fb_t_d = mdf_pkg::T_EXEC_COMMON;
		case (id_q)
			mdf_pkg::ID_DOUBLE, mdf_pkg::ID_SINGLE:
				fb_t_d = mdf_pkg::T_EXEC_COMMON;
			mdf_pkg::ID_CMPBIT: fb_t_d = mdf_pkg::T_TEST_EXEC;
			mdf_pkg::ID_DIV:    fb_t_d = mdf_pkg::T_DIVIDE_EXEC;
			mdf_pkg::ID_JSR:    fb_t_d = mdf_pkg::T_SUB_CALL;
			mdf_pkg::ID_JMP:    fb_t_d = mdf_pkg::T_JUMP_EXEC;
			mdf_pkg::ID_MFU:    fb_t_d = mdf_pkg::T_MOVE_FROM_EX;
			default: begin
				uses_b = 1'b0;
				fb_t_d = mdf_pkg::T_NONE;
			end
		endcase
		uses_c = (id_q == mdf_pkg::ID_DOUBLE) ||
			(id_q == mdf_pkg::ID_CMPBIT) || (id_q == mdf_pkg::ID_MOVE);
		fc_t_d = uses_c ? sto_tgt : mdf_pkg::T_NONE;
		// targets change only when a user consults its fork
		if (!(fork_b_req && uses_b)) begin
			fb_t_d = fb_t_q;
		end
		if (!(fork_c_req && uses_c)) begin
			fc_t_d = fc_t_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// next values
	always_comb begin
		phase_d = mdf_pkg::PH_WAIT;
		ir_d    = ir_q;
		br_d    = br_q;
		id_d    = id_q;
		cyc_d   = cyc_q;
		fa_v_d  = 1'b0;
		// answer only users, otherwise flag unused
		fb_v_d  = fork_b_req && uses_b;
		fc_v_d  = fork_c_req && uses_c;
		nu_d    = (fork_b_req && !uses_b) || (fork_c_req && !uses_c);
		if (fetch_load) begin
			ir_d    = fetch_word;
			br_d    = fetch_word;
			phase_d = mdf_pkg::PH_DECODE;
		end
		case (phase_q)
			mdf_pkg::PH_WAIT: begin
			end
			// fork a answers from decode state
			mdf_pkg::PH_DECODE: begin
				fa_v_d = 1'b1;
				id_d   = id_c;
				cyc_d  = cyc_c;
			end
			default: phase_d = mdf_pkg::PH_WAIT;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_q <= mdf_pkg::PH_WAIT;
			ir_q    <= mdf_pkg::WORD_RST;
			br_q    <= mdf_pkg::WORD_RST;
			id_q    <= mdf_pkg::ID_NONE;
			cyc_q   <= mdf_pkg::CYC_NONE;
			fa_v_q  <= 1'b0;
			fa_t_q  <= mdf_pkg::T_NONE;
			fb_v_q  <= 1'b0;
			fb_t_q  <= mdf_pkg::T_NONE;
			fc_v_q  <= 1'b0;
			fc_t_q  <= mdf_pkg::T_NONE;
			nu_q    <= 1'b0;
		end else begin
			phase_q <= phase_d;
			ir_q    <= ir_d;
			br_q    <= br_d;
			id_q    <= id_d;
			cyc_q   <= cyc_d;
			fa_v_q  <= fa_v_d;
			fa_t_q  <= fa_t_d;
			fb_v_q  <= fb_v_d;
			fb_t_q  <= fb_t_d;
			fc_v_q  <= fc_v_d;
			fc_t_q  <= fc_t_d;
			nu_q    <= nu_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from flip-flops
	assign instruction_register = ir_q;
	assign buffer_register      = br_q;
	assign instr_id             = id_q;
	assign dest_fetch_cycle     = cyc_q;
	assign fork_a_valid         = fa_v_q;
	assign fork_a_target        = fa_t_q;
	assign fork_b_valid         = fb_v_q;
	assign fork_b_target        = fb_t_q;
	assign fork_c_valid         = fc_v_q;
	assign fork_c_target        = fc_t_q;
	assign fork_unused          = nu_q;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_LOAD_BOTH: assert property (
		fetch_load |=> (ir_q == $past(fetch_word)) && (br_q == ir_q))
		else $error("fetched word not in both holding registers");
	AST_FORK_A_TIME: assert property (
		fetch_load |=> ##1 fa_v_q)
		else $error("fork a did not answer two cycles after load");
	AST_FORK_A_CAUSE: assert property (
		fa_v_q |-> $past(phase_q) == mdf_pkg::PH_DECODE)
		else $error("fork a answered outside decode");
	AST_FETCH_RETURN: assert property (
		(phase_q == mdf_pkg::PH_DECODE && id_c == mdf_pkg::ID_BRCOND &&
		!branch_condition_met) |=> fa_t_q ==
		($past(async_request) ? mdf_pkg::T_FETCH_START
		: mdf_pkg::T_FETCH_SECOND))
		else $error("wrong fetch return state");
	AST_BRANCH_TAKE: assert property (
		(phase_q == mdf_pkg::PH_DECODE && id_c == mdf_pkg::ID_BRCOND &&
		branch_condition_met) |=> fa_t_q == mdf_pkg::T_BRANCH_TAKE)
		else $error("branch not taken");
	AST_TRAP: assert property (
		(phase_q == mdf_pkg::PH_DECODE && id_c == mdf_pkg::ID_TRAP)
		|=> fa_t_q == mdf_pkg::T_TRAP_ENTRY)
		else $error("trap not sent to trap entry");
	AST_DIV_REG: assert property (
		(phase_q == mdf_pkg::PH_DECODE && id_c == mdf_pkg::ID_DIV &&
		dest_mode_zero) |=> fa_t_q == mdf_pkg::T_DIVIDE_SETUP)
		else $error("divide register mode not sent to setup");
	AST_SRC_MODE: assert property (
		(phase_q == mdf_pkg::PH_DECODE && id_c == mdf_pkg::ID_DOUBLE &&
		ir_q[11:9] == 3'h4) |=> fa_t_q == mdf_pkg::T_SRC_M45)
		else $error("source mode 4 dispatch wrong");
	AST_UNUSED_B: assert property (
		(fork_b_req && !uses_b) |=> fork_unused && !fork_b_valid)
		else $error("unused fork b answered");
	AST_CLASS_MOVE: assert property (
		(phase_q == mdf_pkg::PH_DECODE && ir_q[15:12] == 4'h1)
		|=> dest_fetch_cycle == mdf_pkg::CYC_WRITE)
		else $error("word move does not end with a write");

	COV_BRANCH: cover property (fa_v_q && fa_t_q == mdf_pkg::T_BRANCH_TAKE);
	COV_FORK_B: cover property (fb_v_q && fb_t_q == mdf_pkg::T_DIVIDE_EXEC);
	COV_FORK_C: cover property (fc_v_q);
	COV_UNUSED: cover property (nu_q);

endmodule

// >>> test/mdf_seq_model.sv
// behavioural sequencer and fetch unit facing the dispatch forks
// assumes callers sit at a falling clock edge when they call a task
module mdf_seq_model (
	input  wire logic        clk,
	output      logic        fetch_load,
	output      logic [15:0] fetch_word,
	output      logic        fork_b_req,
	output      logic        fork_c_req
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////
	// idle levels at time zero
	initial begin
		fetch_load = 1'b0;
		fetch_word = 16'hA5C3; // released bus shows a pattern
		fork_b_req = 1'b0;
		fork_c_req = 1'b0;
	end

	////////////////////////////////////////
	// one fetched word, load pulse of one cycle
	task automatic issue_fetch(input logic [15:0] w);
		fetch_load = 1'b1;
		fetch_word = w;
		@(negedge clk);
		fetch_load = 1'b0;
		// released bus: inverse of last word, not a stale copy
		fetch_word = ~w;
	endtask

	////////////////////////////////////////
	// raise or drop the fork consult strobes
	task automatic set_req(input logic b, input logic c);
		fork_b_req = b;
		fork_c_req = c;
	endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the dispatch forks
// assumes the sequencer model drives fetch and fork requests
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;                  // processor clock
	logic        rstn;                 // async reset, active low
	logic        async_request;        // pending request level
	logic        branch_condition_met; // branch condition level
	logic        fetch_load;           // from model
	logic [15:0] fetch_word;           // from model
	logic        fork_b_req;           // from model
	logic        fork_c_req;           // from model
	logic [15:0] instruction_register; // held word
	logic [15:0] buffer_register;      // held copy
	logic [3:0]  instr_id;             // decoded identity
	logic [1:0]  dest_fetch_cycle;     // last transfer kind
	logic        fork_a_valid;         // fork a strobe
	logic [4:0]  fork_a_target;        // fork a answer
	logic        fork_b_valid;         // fork b strobe
	logic [4:0]  fork_b_target;        // fork b answer
	logic        fork_c_valid;         // fork c strobe
	logic [4:0]  fork_c_target;        // fork c answer
	logic        fork_unused;          // fork asked but unused
	int          err_count;            // mismatches
	int          comparisons;          // compares made

	////////////////////////////////////////
	// clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	mdf_seq_model model (
		.clk        (clk),
		.fetch_load (fetch_load),
		.fetch_word (fetch_word),
		.fork_b_req (fork_b_req),
		.fork_c_req (fork_c_req)
	);

	mdf_dispatch uut (
		.clk                  (clk),
		.rstn                 (rstn),
		.fetch_load           (fetch_load),
		.fetch_word           (fetch_word),
		.async_request        (async_request),
		.branch_condition_met (branch_condition_met),
		.fork_b_req           (fork_b_req),
		.fork_c_req           (fork_c_req),
		.instruction_register (instruction_register),
		.buffer_register      (buffer_register),
		.instr_id             (instr_id),
		.dest_fetch_cycle     (dest_fetch_cycle),
		.fork_a_valid         (fork_a_valid),
		.fork_a_target        (fork_a_target),
		.fork_b_valid         (fork_b_valid),
		.fork_b_target        (fork_b_target),
		.fork_c_valid         (fork_c_valid),
		.fork_c_target        (fork_c_target),
		.fork_unused          (fork_unused)
	);

	////////////////////////////////////////
	// compare and report
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////
	// expected fork a target; 5'h1F means not judged
	function automatic logic [4:0] exp_a(input logic [15:0] w,
		input logic [3:0] id, input logic bc, input logic ar);
		logic [2:0] sm;
		logic [2:0] dm;
		logic [4:0] dt;
		sm = w[11:9];
		dm = w[5:3];
		dt = mdf_pkg::DST_TABLE[5*dm +: 5];
		case (id)
			mdf_pkg::ID_DOUBLE, mdf_pkg::ID_CMPBIT, mdf_pkg::ID_MOVE:
				exp_a = (sm != 3'h0) ? mdf_pkg::SRC_TABLE[5*sm +: 5] : dt;
			mdf_pkg::ID_SINGLE: exp_a = dt;
			mdf_pkg::ID_BRCOND: exp_a = bc ? mdf_pkg::T_BRANCH_TAKE :
				(ar ? mdf_pkg::T_FETCH_START : mdf_pkg::T_FETCH_SECOND);
			mdf_pkg::ID_BRUNC: exp_a = mdf_pkg::T_BRANCH_TAKE;
			mdf_pkg::ID_DIV:
				exp_a = (dm == 3'h0) ? mdf_pkg::T_DIVIDE_SETUP : dt;
			mdf_pkg::ID_JSR, mdf_pkg::ID_JMP:
				exp_a = (dm == 3'h0) ? mdf_pkg::T_TRAP_ENTRY : dt;
			mdf_pkg::ID_MFU:
				exp_a = (dm == 3'h0) ? mdf_pkg::T_MOVE_FROM_REG : dt;
			mdf_pkg::ID_TRAP, mdf_pkg::ID_NONE:
				exp_a = mdf_pkg::T_TRAP_ENTRY;
			default: exp_a = 5'h1F;
		endcase
	endfunction

	// expected last destination transfer; 3'h4 means not judged
	function automatic logic [2:0] exp_cyc(input logic [15:0] w,
		input logic [3:0] id);
		case (id)
			mdf_pkg::ID_MOVE: exp_cyc = w[15] ?
				3'(mdf_pkg::CYC_READ_PAUSE) : 3'(mdf_pkg::CYC_WRITE);
			mdf_pkg::ID_CMPBIT, mdf_pkg::ID_DIV, mdf_pkg::ID_MFU:
				exp_cyc = 3'(mdf_pkg::CYC_READ);
			mdf_pkg::ID_DOUBLE: exp_cyc = 3'(mdf_pkg::CYC_READ_PAUSE);
			mdf_pkg::ID_BRCOND, mdf_pkg::ID_BRUNC, mdf_pkg::ID_TRAP:
				exp_cyc = 3'(mdf_pkg::CYC_NONE);
			default: exp_cyc = 3'h4;
		endcase
	endfunction

	////////////////////////////////////////
	// outputs cleared by reset
	task automatic check_idle();
		check(instruction_register, 16'h0000);
		check(buffer_register, 16'h0000);
		check(16'(instr_id), 16'h0000);
		check(16'(fork_a_valid), 16'h0000);
		check(16'(fork_a_target), 16'h0000);
		check(16'(dest_fetch_cycle), 16'h0000);
	endtask

	// fetch one word, return in the cycle fork a answers
	task automatic fetch_and_wait(input logic [15:0] w);
		model.issue_fetch(w);
		check(instruction_register, w);
		check(buffer_register, w);
		check(16'(fork_a_valid), 16'h0000);
		@(negedge clk);
		check(16'(fork_a_valid), 16'h0001);
	endtask

	////////////////////////////////////////
	// compare with source mode 2, then source mode 0
	task automatic cmp_example();
		fetch_and_wait(16'h25F7);
		check(16'(instr_id), 16'(mdf_pkg::ID_CMPBIT));
		check(16'(fork_a_target), 16'(mdf_pkg::T_SRC_M13));
		check(16'(dest_fetch_cycle), 16'(mdf_pkg::CYC_READ));
		@(negedge clk);
		fetch_and_wait(16'h201F);
		check(16'(fork_a_target), 16'(mdf_pkg::T_DST_M30));
	endtask

	// one directed word: identity and fork a target
	task automatic one_word(input logic [15:0] w, input logic [3:0] ide,
		input logic [4:0] te);
		@(negedge clk);
		fetch_and_wait(w);
		check(16'(instr_id), 16'(ide));
		check(16'(fork_a_target), 16'(te));
	endtask

	// words whose identity is fixed by the instruction map
	task automatic id_words();
		one_word(16'h09C0, mdf_pkg::ID_JSR, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h8800, mdf_pkg::ID_TRAP, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h8900, mdf_pkg::ID_TRAP, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h0003, mdf_pkg::ID_TRAP, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h0004, mdf_pkg::ID_TRAP, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h7202, mdf_pkg::ID_DIV, mdf_pkg::T_DIVIDE_SETUP);
		one_word(16'h0D41, mdf_pkg::ID_MFU, mdf_pkg::T_MOVE_FROM_REG);
		one_word(16'h0040, mdf_pkg::ID_JMP, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h0100, mdf_pkg::ID_BRUNC, mdf_pkg::T_BRANCH_TAKE);
		one_word(16'h8E00, mdf_pkg::ID_NONE, mdf_pkg::T_TRAP_ENTRY);
		one_word(16'h7A00, mdf_pkg::ID_NONE, mdf_pkg::T_TRAP_ENTRY);
	endtask

	// expected fork b target of a user
	function automatic logic [4:0] exp_b(input logic [3:0] id);
		case (id)
			mdf_pkg::ID_CMPBIT: exp_b = mdf_pkg::T_TEST_EXEC;
			mdf_pkg::ID_DIV:    exp_b = mdf_pkg::T_DIVIDE_EXEC;
			mdf_pkg::ID_JSR:    exp_b = mdf_pkg::T_SUB_CALL;
			mdf_pkg::ID_JMP:    exp_b = mdf_pkg::T_JUMP_EXEC;
			mdf_pkg::ID_MFU:    exp_b = mdf_pkg::T_MOVE_FROM_EX;
			default:            exp_b = mdf_pkg::T_EXEC_COMMON;
		endcase
	endfunction

	// sweep words, conditions, and back-to-back fork consults
	task automatic scan_words();
		logic [15:0] w;
		logic [4:0]  e;
		logic [4:0]  old_c;
		logic [4:0]  old_b;
		logic [3:0]  id;
		logic [2:0]  ec;
		logic        ub;
		logic        uc;
		for (int i = 0; i < 112; i++) begin
			w = 16'(i * 585);
			branch_condition_met = i[0];
			async_request = i[1];
			fetch_and_wait(w);
			id = instr_id;
			e = exp_a(w, id, i[0], i[1]);
			ec = exp_cyc(w, id);
			if (e != 5'h1F) check(16'(fork_a_target), 16'(e));
			if (ec != 3'h4) check(16'(dest_fetch_cycle), 16'(ec));
			ub = id inside {mdf_pkg::ID_DOUBLE, mdf_pkg::ID_CMPBIT,
				mdf_pkg::ID_SINGLE, mdf_pkg::ID_DIV, mdf_pkg::ID_JSR,
				mdf_pkg::ID_JMP, mdf_pkg::ID_MFU};
			uc = id inside {mdf_pkg::ID_DOUBLE, mdf_pkg::ID_CMPBIT,
				mdf_pkg::ID_MOVE};
			old_c = fork_c_target;
			old_b = fork_b_target;
			model.set_req(1'b1, 1'b0);
			@(negedge clk);
			check(16'(fork_a_valid), 16'h0000);
			model.set_req(1'b0, 1'b1);
			@(negedge clk);
			// other identities are not judged on forks b and c
			if (id !== mdf_pkg::ID_OTHER) begin
				check(16'(fork_c_valid), 16'(uc));
				check(16'(fork_unused), 16'(!uc));
				check(16'(fork_c_target), 16'(uc ?
					mdf_pkg::STO_TABLE[5*w[5:3] +: 5] : old_c));
			end
			model.set_req(1'b0, 1'b0);
			// at least one idle edge before the next consult
			repeat (1 + i % 3) @(negedge clk);
			// fork b alone, after a varying gap
			model.set_req(1'b1, 1'b0);
			@(negedge clk);
			model.set_req(1'b0, 1'b0);
			if (id !== mdf_pkg::ID_OTHER) begin
				check(16'(fork_b_valid), 16'(ub));
				check(16'(fork_unused), 16'(!ub));
				check(16'(fork_b_target),
					16'(ub ? exp_b(id) : old_b));
			end
		end
	endtask

	// reset in mid-run, then decode again
	task automatic mid_reset();
		@(negedge clk);
		rstn = 1'b0;
		@(negedge clk);
		check_idle();
		rstn = 1'b1;
		@(negedge clk);
		fetch_and_wait(16'h25F7);
		check(16'(fork_a_target), 16'(mdf_pkg::T_SRC_M13));
	endtask

	////////////////////////////////////////
	// watchdog against a hang
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		summarize();
	end

	// main sequence
	initial begin
		err_count = 0;
		comparisons = 0;
		rstn = 1'b0;
		async_request = 1'b0;
		branch_condition_met = 1'b0;
		repeat (5) @(negedge clk);
		check_idle();
		rstn = 1'b1;
		@(negedge clk);
		cmp_example();
		id_words();
		@(negedge clk);
		scan_words();
		mid_reset();
		summarize();
	end
endmodule
